// ===== general_purpose_io_pin_logic_tb.sv
// testbench: pin decode, toggle, break-before-make, read path and clamp
`timescale 1ns/1ps
`default_nettype none
module general_purpose_io_pin_logic_tb;
    import gpp_pkg::*;
    localparam int W = GPP_NUM_PORTS * GPP_PORT_WIDTH;
    logic clk_sys = 1'b0, rst_n = 1'b0, gpd = 1'b0, clamp = 1'b0;
    logic [1:0] dir_we = '0, out_we = '0, tog_we = '0, ppd = '0, bbm = '0;
    logic [W-1:0] wdata = '0, inten = '0, ext_en = 16'h00F0, ext_val = '0;
    logic [W-1:0] pin_in, pin_out, pin_oe, pu, dirb, outb, rd;
    int num_errors = 0, checks = 0;
    // design and the circuitry on its pins
    gpp_port u_gpp_port (.clk_sys(clk_sys), .rst_n(rst_n), .dir_we(dir_we),
        .dir_wdata(wdata), .out_we(out_we), .out_wdata(wdata), .toggle_we(tog_we),
        .toggle_wdata(wdata), .global_pullup_disable(gpd), .port_pullup_disable(ppd),
        .break_before_make_enable(bbm), .sleep_clamp_req(clamp),
        .ext_int_enable(inten), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pu), .direction_register_bit(dirb), .output_value_bit(outb),
        .pin_read_toggle_bit(rd));
    gpp_pin_model #(.W(W)) u_gpp_pin_model (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pu), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;
    task chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write cycle, strobes dropped at the taking edge
    task wr(input logic [1:0] d, input logic [1:0] o, input logic [1:0] t,
            input logic [W-1:0] v);
        @(posedge clk_sys);
        dir_we <= d; out_we <= o; tog_we <= t; wdata <= v;
        @(posedge clk_sys);
        dir_we <= '0; out_we <= '0; tog_we <= '0;
        #1;
    endtask : wr
    task settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle
    task t_decode;
        wr(2'b00, 2'b11, 2'b00, 16'hFFFF);
        chk("pullup", 16'hFFFF, pu);
        @(posedge clk_sys);
        gpd <= 1'b1;
        settle(1);
        chk("pullup_gpd", 16'h0000, pu);
        @(posedge clk_sys);
        gpd <= 1'b0; ppd <= 2'b01;
        settle(1);
        chk("pullup_ppd", 16'hFF00, pu);
        @(posedge clk_sys);
        ppd <= 2'b00;
        wr(2'b11, 2'b00, 2'b00, 16'h0F0F);
        chk("dir", 16'h0F0F, dirb);
        chk("oe", 16'h0F0F, pin_oe);
        chk("pullup_mix", 16'hF0F0, pu);
    endtask : t_decode
    task t_bbm;
        @(posedge clk_sys);
        bbm <= 2'b01;
        wr(2'b11, 2'b00, 2'b00, 16'h1F1F);
        chk("oe_break", 16'h1F0F, pin_oe);
        settle(1);
        chk("oe_make", 16'h1F1F, pin_oe);
        wr(2'b11, 2'b00, 2'b00, 16'h0F0F);
        chk("oe_to_in", 16'h0F0F, pin_oe);
    endtask : t_bbm
    task t_toggle;
        wr(2'b00, 2'b00, 2'b11, 16'h8001);
        chk("toggle", 16'h7FFE, outb);
        chk("pin_out", 16'h7FFE, pin_out);
        settle(2);
        wr(2'b00, 2'b00, 2'b11, 16'h0001);
        chk("read_early", 16'h7F0E, rd & 16'h7FFF);
        settle(1);
        chk("read_back", 16'h7F0F, rd & 16'h7FFF);
    endtask : t_toggle
    task t_clamp;
        @(posedge clk_sys);
        clamp <= 1'b1; inten <= 16'h1000;
        settle(3);
        chk("clamped", 16'h1000, rd & 16'h7FFF);
        @(posedge clk_sys);
        clamp <= 1'b0;
        settle(3);
        chk("released", 16'h7F0F, rd & 16'h7FFF);
    endtask : t_clamp
    task results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        chk("rst_oe", 16'h0000, pin_oe | pu | rd);
        rst_n <= 1'b1;
        t_decode();
        t_bbm();
        t_toggle();
        t_clamp();
        rst_n <= 1'b0;
        #1;
        chk("rst_mid", 16'h0000, pin_oe | pu);
        results();
    end
    // watchdog
    initial
    begin
        #10000;
        num_errors++;
        results();
    end
endmodule : general_purpose_io_pin_logic_tb
`default_nettype wire

// ===== gpp_pin_model.sv
// partner model: external circuitry seen at the pins
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model
#(
    parameter int W = 16
)
(
    input  wire logic         clk_sys,
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pin_pullup_en,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output var  logic [W-1:0] pin_in
);
    logic [W-1:0] flt = '0;
    // undriven lines wander every cycle, so no stale level survives
    always @(posedge clk_sys)
    begin
        flt <= ~flt;
    end
    // driver wins, then outside drive, then pull-up, else floating
    always_comb
    begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pin_pullup_en | flt));
    end
endmodule : gpp_pin_model
`default_nettype wire

// ===== gpp_pin_sync.sv
// module: one pin's input clamp and two-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_sync
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pin_level,
    input  wire logic clamp,
    output var  logic read_level
);
    import gpp_pkg::*;

    logic hold_stage;
    logic next_hold;
    logic next_read;

    // clamp ahead of the synchroniser, then falling-edge hold and rising-edge load
    always_comb
    begin
        next_hold = pin_level & ~clamp;     // [RL13]
        next_read = hold_stage;             // [RL11]
    end

    // first stage: takes the level present when the clock falls
    always_ff @(negedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hold_stage <= GPP_SYNC_RST;     // [RL20]
        else
            hold_stage <= next_hold;        // [RL11]
    end

    // second stage: the readable pin value
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            read_level <= GPP_SYNC_RST;     // [RL20]
        else
            read_level <= next_read;        // [RL10] [RL11]
    end
endmodule : gpp_pin_sync
`default_nettype wire

// ===== gpp_pkg.sv
// package: sizes and reset values for the general purpose pin logic
`default_nettype none
package gpp_pkg;
    localparam int          GPP_NUM_PORTS  = 2;    // ports in the block
    localparam int          GPP_PORT_WIDTH = 8;    // pins per port
    localparam logic        GPP_DIR_RST    = 1'b0; // direction bit after reset: input
    localparam logic        GPP_OUT_RST    = 1'b0; // output value bit after reset
    localparam logic        GPP_OE_RST     = 1'b0; // pin driver after reset: off
    localparam logic        GPP_PU_RST     = 1'b0; // pull-up after reset: off
    localparam logic        GPP_SYNC_RST   = 1'b0; // synchroniser stages after reset
endpackage : gpp_pkg
`default_nettype wire

// ===== gpp_port.sv
// module: general purpose digital pin logic for a group of ports
//
// How it works
// [RL1] writing one to a pin read bit inverts its output value bit
// [RL2] with break-before-make, input to output keeps the pin off one cycle
// [RL3] break-before-make is chosen per port and covers all its pins
// [RL4] output to input never inserts an off cycle
// [RL5] software changes a direction bit at most once per two cycles
// [RL6] dir 0 out 0 floats, dir 0 out 1 pulls up, dir 1 drives
// [RL7] global or port pull-up disable alone suppresses the pull-ups
// [RL8] software goes via pull-up or output low between float and high
// [RL9] software goes via float or output high between pull-up and low
// [RL10] the pin level is readable whatever the direction
// [RL11] input held at clock fall, loaded into read bit at next rise
// [RL12] a driven value reads back one cycle later; software waits one slot
// [RL13] sleep clamp forces the digital input low before the synchroniser
// [RL14] clamp is lifted on pins whose external interrupt is enabled
// [RL15] clamp release on a high pin gives an edge to the interrupt logic
// [RL16] pull-ups are off throughout reset
// [RL17] direction one makes an output, zero an input
// [RL18] all pins float as soon as reset is active, clock or not
// [RL19] port pull-up disable is ored with the global pull-up disable
// [RL20] synchroniser and read bits clear to zero at reset
`timescale 1ns/1ps
`default_nettype none
module gpp_port
#(
    parameter int NUM_PORTS  = gpp_pkg::GPP_NUM_PORTS,
    parameter int PORT_WIDTH = gpp_pkg::GPP_PORT_WIDTH
)
(
    input  wire logic                              clk_sys,
    input  wire logic                              rst_n,
    input  wire logic [NUM_PORTS-1:0]              dir_we,
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   dir_wdata,
    input  wire logic [NUM_PORTS-1:0]              out_we,
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   out_wdata,
    input  wire logic [NUM_PORTS-1:0]              toggle_we,
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   toggle_wdata,
    input  wire logic                              global_pullup_disable,
    input  wire logic [NUM_PORTS-1:0]              port_pullup_disable,
    input  wire logic [NUM_PORTS-1:0]              break_before_make_enable,
    input  wire logic                              sleep_clamp_req,
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   ext_int_enable,
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_in,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_out,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_oe,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_pullup_en,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   direction_register_bit,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   output_value_bit,
    output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_read_toggle_bit
);
    import gpp_pkg::*;

    localparam int NPINS = NUM_PORTS * PORT_WIDTH;

    logic [NPINS-1:0] next_dir;
    logic [NPINS-1:0] next_out;
    logic [NPINS-1:0] next_oe;
    logic [NPINS-1:0] next_pu;
    logic [NPINS-1:0] clamp_act;
    logic [NPINS-1:0] pud_mask;
    logic [NPINS-1:0] bbm_mask;
    logic [NPINS-1:0] toggle_masked;

    // clamp applies in sleep unless the pin's external interrupt is enabled
    assign clamp_act = {NPINS{sleep_clamp_req}} & ~ext_int_enable;   // [RL13] [RL14]

    // per-pin copies of the port-wide pull-up disable and break-before-make bits
    always_comb
    begin
        pud_mask = '0;
        bbm_mask = '0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            pud_mask[p*PORT_WIDTH +: PORT_WIDTH] =
                {PORT_WIDTH{global_pullup_disable | port_pullup_disable[p]}};  // [RL7] [RL19]
            bbm_mask[p*PORT_WIDTH +: PORT_WIDTH] =
                {PORT_WIDTH{break_before_make_enable[p]}};                     // [RL3]
        end
    end

    // next register values: writes, toggles, driver and pull-up decode
    always_comb
    begin
        next_dir = direction_register_bit;
        next_out = output_value_bit;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (dir_we[p])
                next_dir[p*PORT_WIDTH +: PORT_WIDTH] = dir_wdata[p*PORT_WIDTH +: PORT_WIDTH];
            if (out_we[p])
                next_out[p*PORT_WIDTH +: PORT_WIDTH] = out_wdata[p*PORT_WIDTH +: PORT_WIDTH];
            // toggle applies on top of a same-cycle write, whatever the direction
            if (toggle_we[p])
                next_out[p*PORT_WIDTH +: PORT_WIDTH] =
                    next_out[p*PORT_WIDTH +: PORT_WIDTH]
                    ^ toggle_wdata[p*PORT_WIDTH +: PORT_WIDTH];                // [RL1]
        end
        // driver follows direction; a rising direction bit under bbm waits one cycle
        next_oe = next_dir & ~(bbm_mask & next_dir & ~direction_register_bit); // [RL2] [RL4] [RL17]
        // pull-up only for input with output bit high and no disable
        next_pu = ~next_dir & next_out & ~pud_mask;                            // [RL6] [RL7]
    end

    // pin control registers; reset floats every pin at once, no clock needed
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            direction_register_bit <= {NPINS{GPP_DIR_RST}};
            output_value_bit       <= {NPINS{GPP_OUT_RST}};
            pin_oe                 <= {NPINS{GPP_OE_RST}};   // [RL18]
            pin_pullup_en          <= {NPINS{GPP_PU_RST}};   // [RL16]
            pin_out                <= {NPINS{GPP_OUT_RST}};
        end
        else
        begin
            direction_register_bit <= next_dir;              // [RL17]
            output_value_bit       <= next_out;
            pin_oe                 <= next_oe;               // [RL2]
            pin_pullup_en          <= next_pu;               // [RL6]
            pin_out                <= next_out;              // [RL6] [RL12]
        end
    end

    // input synchronisers, one per pin; a clamp release on a high pin is a rising edge
    generate
        for (genvar i = 0; i < NPINS; i++)
        begin : g_sync
            gpp_pin_sync u_sync
            (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .pin_level  (pin_in[i]),
                .clamp      (clamp_act[i]),            // [RL15]
                .read_level (pin_read_toggle_bit[i])   // [RL10]
            );
        end
    endgenerate

    // checks on the control and read paths
    a_toggle_inverts_out: assert property (                                   // [RL1]
        @(posedge clk_sys) disable iff (!rst_n)
        (out_we == '0) |=> output_value_bit == ($past(output_value_bit)
            ^ $past(toggle_masked)))
        else $error("output bit not inverted by toggle write");

    // toggle data gated by the per-port strobe, for the toggle check only
    always_comb
    begin
        toggle_masked = '0;
        for (int p = 0; p < NUM_PORTS; p++)
            if (toggle_we[p])
                toggle_masked[p*PORT_WIDTH +: PORT_WIDTH] =
                    toggle_wdata[p*PORT_WIDTH +: PORT_WIDTH];
    end

    a_write_sets_out: assert property (                                       // [RL6]
        @(posedge clk_sys) disable iff (!rst_n)
        (out_we == '1 && toggle_we == '0) |=> output_value_bit == $past(out_wdata))
        else $error("output bit does not take written value");

    a_bbm_break_cycle: assert property (                                      // [RL2]
        @(posedge clk_sys) disable iff (!rst_n)
        ((pin_oe & $past(bbm_mask) & direction_register_bit
            & ~$past(direction_register_bit)) == '0))
        else $error("pin driven in the break-before-make cycle");

    a_bbm_make_next: assert property (                                        // [RL2]
        @(posedge clk_sys) disable iff (!rst_n)
        (dir_we == '0 && $past(dir_we) == '0) |-> pin_oe == direction_register_bit)
        else $error("driver not on after break-before-make cycle");

    a_no_bbm_direct: assert property (                                        // [RL3]
        @(posedge clk_sys) disable iff (!rst_n)
        ($past(break_before_make_enable) == '0) |-> pin_oe == direction_register_bit)
        else $error("driver delayed without break-before-make");

    a_out_to_in_off: assert property (                                        // [RL4]
        @(posedge clk_sys) disable iff (!rst_n)
        ((pin_oe & ~direction_register_bit) == '0))
        else $error("driver left on for an input pin");

    a_pullup_decode: assert property (                                        // [RL7]
        @(posedge clk_sys) disable iff (!rst_n)
        pin_pullup_en == (~direction_register_bit & output_value_bit
            & ~$past(pud_mask)))
        else $error("pull-up decode wrong");

    a_clamp_reads_low: assert property (                                      // [RL13]
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 ((pin_read_toggle_bit & $past(clamp_act)) == '0))
        else $error("clamped pin reads high");

    a_drive_matches_out: assert property (                                    // [RL12]
        @(posedge clk_sys) disable iff (!rst_n)
        (out_we != '0) |=> pin_out == output_value_bit)
        else $error("pin level differs from output value bit");

endmodule : gpp_port
`default_nettype wire
